/* File: dv/eeprom_two_wire_slave_front_end_bench.sv */
/* Self-checking bench: host end and front end joined on one link.
   Assumes short link timing (QTR 8, 20-cycle power-up wait); inputs
   move on falling mclk. */
`timescale 1ns/100ps
`default_nettype none
module eeprom_two_wire_slave_front_end_bench;
    localparam logic [6:0] SEL = 7'h50;
    localparam int QTR = 8;
    logic mclk, rst_b, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_ack;
    tw_pkg::cmd_t cmd_kind;
    logic [7:0] cmd_data, rsp_data, tx_data, rx_data;
    logic [6:0] sel_code;
    logic wr_busy, rx_valid, rx_is_addr, rd_mode, tx_take;
    logic start_seen, stop_seen, standby;
    logic [8:0] rx_q [$];
    logic [7:0] tx_tab [4] = '{8'ha5, 8'h96, 8'hc3, 8'h00};
    logic [7:0] wr_tab [3] = '{8'h81, 8'h3c, 8'h00};
    logic [1:0] tx_ix = 2'h0;
    int num_errors = 0;
    int n_compared = 0;
    int n_start = 0;
    int n_stop = 0;
    int cyc = 0;

    tw_link_if tw_link_if_i ();
    tw_master_end #(.QTR(QTR), .PWR_WAIT(20)) tw_master_end_i (.mclk(mclk),
        .rst_b(rst_b), .clk_en(1'b1), .link(tw_link_if_i),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
        .cmd_last(cmd_last), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_ack(rsp_ack));
    tw_slave_end tw_slave_end_i (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1),
        .link(tw_link_if_i), .sel_code(sel_code), .wr_busy(wr_busy),
        .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_is_addr(rx_is_addr), .rd_mode(rd_mode), .tx_take(tx_take),
        .start_seen(start_seen), .stop_seen(stop_seen), .standby(standby));
    tw_link_props tw_link_props_i (.mclk(mclk), .rst_b(rst_b),
        .scl(tw_link_if_i.scl), .m_sda_oe(tw_link_if_i.m_sda_oe),
        .s_sda_oe(tw_link_if_i.s_sda_oe), .sda(tw_link_if_i.sda));

    assign tx_data = tx_tab[tx_ix];

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ***********************************
    // Monitors and timeout
    // ***********************************
    always @(negedge mclk) begin
        if (rx_valid === 1'b1)
            rx_q.push_back({rx_is_addr, rx_data});
        if (start_seen === 1'b1)
            n_start++;
        if (stop_seen === 1'b1)
            n_stop++;
        // Next byte must be ready before the following take
        if (tx_take === 1'b1)
            tx_ix <= tx_ix + 2'h1;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // ***********************************
    // Tasks
    // ***********************************
    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({8'h00, got}, {8'h00, exp});
    endtask

    // Called at a falling edge; returns at the first falling edge with rsp_valid high
    task automatic do_cmd(input tw_pkg::cmd_t kind, input logic [7:0] d,
            input logic last);
        int n;
        int exp_n;
        cmd_kind = kind;
        cmd_data = d;
        cmd_last = last;
        cmd_valid = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        chk_flag(rsp_valid, 1'b1);
        // Nine clocks of four quarters per byte, one clock for framing
        exp_n = (kind == tw_pkg::CMD_WRITE || kind == tw_pkg::CMD_READ) ?
            36 * QTR : 4 * QTR;
        if (kind != tw_pkg::CMD_RECOVER)
            chk_val(9'(n), 9'(exp_n));
    endtask

    task automatic put_byte(input logic [7:0] b, input logic ack,
            input logic is_addr);
        logic [8:0] got;
        do_cmd(tw_pkg::CMD_WRITE, b, 1'b0);
        chk_flag(rsp_ack, ack);
        got = (rx_q.size() > 0) ? rx_q.pop_front() : 9'bx;
        chk_val(got, {is_addr, b});
    endtask

    task automatic get_byte(input logic [7:0] exp, input logic last);
        do_cmd(tw_pkg::CMD_READ, 8'h00, last);
        chk_val({1'b0, rsp_data}, {1'b0, exp});
        chk_flag(rsp_ack, !last);
    endtask

    task automatic settle;
        repeat (8) @(negedge mclk);
    endtask

    task automatic close_out;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ***********************************
    // Sequence
    // ***********************************
    initial begin
        rst_b = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = tw_pkg::CMD_START;
        cmd_data = 8'h00;
        cmd_last = 1'b0;
        sel_code = SEL;
        wr_busy = 1'b0;
        repeat (16) @(negedge mclk);
        chk_flag(tw_link_if_i.sda, 1'b1);
        chk_flag(standby, 1'b0);
        rst_b = 1'b1;
        settle();
        chk_flag(standby, 1'b1);
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        chk_flag(standby, 1'b0);
        put_byte({SEL, 1'b0}, 1'b1, 1'b1);
        foreach (wr_tab[i])
            put_byte(wr_tab[i], 1'b1, 1'b0);
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        put_byte({SEL, 1'b1}, 1'b1, 1'b1);
        chk_flag(rd_mode, 1'b1);
        get_byte(8'ha5, 1'b0);
        get_byte(8'h96, 1'b1);
        do_cmd(tw_pkg::CMD_STOP, 8'h00, 1'b0);
        settle();
        chk_flag(standby, 1'b1);
        chk_val(9'(n_start), 9'h002);
        chk_val(9'(n_stop), 9'h001);
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        put_byte({SEL ^ 7'h01, 1'b0}, 1'b0, 1'b1);
        do_cmd(tw_pkg::CMD_STOP, 8'h00, 1'b0);
        wr_busy = 1'b1;
        settle();
        chk_flag(standby, 1'b0);
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        do_cmd(tw_pkg::CMD_WRITE, {SEL, 1'b0}, 1'b0);
        chk_flag(rsp_ack, 1'b0);
        do_cmd(tw_pkg::CMD_STOP, 8'h00, 1'b0);
        rx_q.delete();
        wr_busy = 1'b0;
        settle();
        chk_flag(standby, 1'b1);
        // Slave left driving a zero byte when the host breaks off
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        put_byte({SEL, 1'b1}, 1'b1, 1'b1);
        get_byte(8'hc3, 1'b0);
        do_cmd(tw_pkg::CMD_RECOVER, 8'h00, 1'b0);
        chk_flag(rsp_ack, 1'b1);
        do_cmd(tw_pkg::CMD_START, 8'h00, 1'b0);
        put_byte({SEL, 1'b0}, 1'b1, 1'b1);
        do_cmd(tw_pkg::CMD_STOP, 8'h00, 1'b0);
        settle();
        chk_flag(standby, 1'b1);
        // Framing sent during the write cycle must not be counted
        chk_val(9'(n_start), 9'h005);
        chk_val(9'(n_stop), 9'h003);
        close_out();
    end
endmodule // eeprom_two_wire_slave_front_end_bench
`default_nettype wire

/* File: dv/tw_link_props.sv */
/* Wire-level checks on the link joining the host end and the front end.
   Assumes clean pin levels, sampled here on mclk without a filter. */
`timescale 1ns/100ps
`default_nettype none
module tw_link_props (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic sda
);
    // ***********************************
    // Frame tracking
    // ***********************************
    logic scl_q, sda_q, in_frame_r, first_r, nack_r;
    logic [3:0] cnt_r, hold_r;
    logic rise, start_ev, stop_ev;
    assign rise = scl && !scl_q;
    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev = scl && scl_q && !sda_q && sda;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            in_frame_r <= 1'b0;
            first_r <= 1'b0;
            nack_r <= 1'b0;
            cnt_r <= 4'h0;
            hold_r <= 4'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev || stop_ev) begin
                in_frame_r <= start_ev;
                first_r <= start_ev;
                cnt_r <= 4'h0;
            end else if (rise) begin
                cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
            end else if (!scl && scl_q && cnt_r == 4'h9) begin
                first_r <= 1'b0;
            end
            if (start_ev)
                nack_r <= 1'b0;
            else if (rise && cnt_r == 4'h8)
                nack_r <= sda;
            // Saturate so a stuck line cannot wrap back to a legal count
            if (!s_sda_oe)
                hold_r <= 4'h0;
            else if (rise && hold_r != 4'hf)
                hold_r <= hold_r + 4'h1;
        end
    end

    // ***********************************
    // Properties
    // ***********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    drive_after_fall_a: assert property ($rose(s_sda_oe) |->
        !scl && !$past(scl, 3)) else $error("slave pulled SDA near SCL high");
    release_low_a: assert property ($fell(s_sda_oe) |-> !scl)
        else $error("slave released SDA while SCL high");
    silent_idle_a: assert property (s_sda_oe |-> in_frame_r)
        else $error("slave pulled SDA outside a frame");
    one_driver_a: assert property (rise && cnt_r == 4'h8 |->
        !(m_sda_oe && s_sda_oe)) else $error("both ends pull in ack slot");
    ack_held_a: assert property (s_sda_oe && rise && cnt_r == 4'h8 |=>
        s_sda_oe [*4]) else $error("ack dropped in ninth high phase");
    addr_slot_a: assert property (s_sda_oe && first_r |->
        cnt_r >= 4'h8) else $error("slave pulled SDA during address bits");
    nack_release_a: assert property (s_sda_oe |-> !nack_r)
        else $error("slave drove SDA after master NACK");
    recover_bound_a: assert property (hold_r <= 4'h9)
        else $error("slave held SDA low beyond nine clocks");
    whole_bytes_a: assert property (stop_ev |-> cnt_r == 4'h1)
        else $error("Stop inside a byte");

    cover property (start_ev && in_frame_r);
    cover property (rise && cnt_r == 4'h8 && sda);
    cover property (hold_r == 4'h8);
endmodule // tw_link_props
`default_nettype wire

/* File: hw/tw_link_if.sv */
/*
 * Two-wire link between host end and memory front end.
 * Assumes both ends pull SDA low through their enables only; the
 * resolved level models the external pull-up.
 */
`timescale 1ns/100ps
`default_nettype none
interface tw_link_if;
    logic scl;
    logic m_sda_oe;
    logic s_sda_oe;
    logic sda;

    // Open-drain wire: low while either end pulls
    assign sda = ~(m_sda_oe | s_sda_oe);

    modport host (output scl, output m_sda_oe, input sda);
    modport device (input scl, input sda, output s_sda_oe);
endinterface
`default_nettype wire

/* File: hw/tw_master_end.sv */
/*
 * Host end of the two-wire link: makes SCL by division and runs
 * Start, Stop, byte and recovery sequences on command.
 * Assumes one command at a time, handed over by valid and ready.
 */
`timescale 1ns/100ps
`default_nettype none
module tw_master_end #(
    parameter int QTR = tw_pkg::QTR_CYC,
    parameter int PWR_WAIT = tw_pkg::PWR_WAIT_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    tw_link_if.host link,
    input wire logic cmd_valid,
    input wire tw_pkg::cmd_t cmd_kind,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_last,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_ack
);
    tw_pkg::ms_reg_t m_r;
    tw_pkg::ms_reg_t m_nxt;
    logic adv;
    logic done;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        m_nxt = m_r;
        m_nxt.rsp_valid = 1'b0;
        m_nxt.sy_a = link.sda;
        m_nxt.sy_b = m_r.sy_a;
        adv = (m_r.tick == 16'(QTR - 1));
        done = 1'b0;
        if (m_r.st != tw_pkg::M_WAIT && m_r.st != tw_pkg::M_IDLE) begin
            m_nxt.tick = adv ? 16'h0 : m_r.tick + 16'h1;
            if (adv) begin
                m_nxt.ph = m_r.ph + 2'h1;
            end
        end
        case (m_r.st)
            tw_pkg::M_WAIT: begin
                // No command before the supply has settled
                if (m_r.pwr_cnt == 12'(PWR_WAIT - 1)) begin
                    m_nxt.st = tw_pkg::M_IDLE;
                    m_nxt.cmd_ready = 1'b1;
                end else begin
                    m_nxt.pwr_cnt = m_r.pwr_cnt + 12'h1;
                end
            end
            tw_pkg::M_IDLE: begin
                if (cmd_valid) begin
                    m_nxt.cmd_ready = 1'b0;
                    m_nxt.tick = 16'h0;
                    m_nxt.ph = 2'h0;
                    m_nxt.bit_cnt = 4'h0;
                    m_nxt.sda_oe = 1'b0;
                    case (cmd_kind)
                        tw_pkg::CMD_START: m_nxt.st = tw_pkg::M_START;
                        tw_pkg::CMD_STOP: begin
                            m_nxt.st = tw_pkg::M_STOP;
                            m_nxt.sda_oe = 1'b1;
                        end
                        tw_pkg::CMD_WRITE: begin
                            // Ninth slot released for the answer
                            m_nxt.st = tw_pkg::M_BYTE;
                            m_nxt.sh = {cmd_data, 1'b1};
                            m_nxt.sda_oe = ~cmd_data[7];
                        end
                        tw_pkg::CMD_READ: begin
                            m_nxt.st = tw_pkg::M_BYTE;
                            m_nxt.sh = {8'hff, cmd_last};
                        end
                        default: m_nxt.st = tw_pkg::M_RECOV;
                    endcase
                end
            end
            tw_pkg::M_START: begin
                if (adv) begin
                    case (m_r.ph)
                        2'h0: m_nxt.scl = 1'b1;
                        2'h1: m_nxt.sda_oe = 1'b1;
                        2'h2: m_nxt.scl = 1'b0;
                        default: done = 1'b1;
                    endcase
                end
            end
            tw_pkg::M_STOP: begin
                if (adv) begin
                    case (m_r.ph)
                        2'h0: m_nxt.scl = 1'b1;
                        2'h1: m_nxt.sda_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b0;
                        default: done = 1'b1;
                    endcase
                end
            end
            tw_pkg::M_BYTE: begin
                // Nine back-to-back clocks, data moved only with SCL low
                if (adv) begin
                    case (m_r.ph)
                        2'h0: m_nxt.scl = 1'b1;
                        2'h1: m_nxt.rsh = {m_r.rsh[7:0], m_r.sy_b};
                        2'h2: m_nxt.scl = 1'b0;
                        default: begin
                            m_nxt.bit_cnt = m_r.bit_cnt + 4'h1;
                            if (m_r.bit_cnt == tw_pkg::BITS_PER_BYTE) begin
                                done = 1'b1;
                                m_nxt.rsp_data = m_r.rsh[8:1];
                                m_nxt.rsp_ack = ~m_r.rsh[0];
                            end else begin
                                m_nxt.sh = {m_r.sh[7:0], 1'b1};
                                m_nxt.sda_oe = ~m_r.sh[7];
                            end
                        end
                    endcase
                end
            end
            default: begin
                // Dummy clocks until the slave lets go of SDA
                if (adv) begin
                    case (m_r.ph)
                        2'h0: m_nxt.scl = 1'b1;
                        2'h1: begin
                            if (m_r.sy_b) begin
                                done = 1'b1;
                                m_nxt.rsp_ack = 1'b1;
                            end
                        end
                        2'h2: m_nxt.scl = 1'b0;
                        default: begin
                            m_nxt.bit_cnt = m_r.bit_cnt + 4'h1;
                            if (m_r.bit_cnt == tw_pkg::RECOVER_CLOCKS - 4'h1)
                                begin
                                done = 1'b1;
                                m_nxt.rsp_ack = 1'b0;
                            end
                        end
                    endcase
                end
            end
        endcase
        if (done) begin
            m_nxt.st = tw_pkg::M_IDLE;
            m_nxt.rsp_valid = 1'b1;
            m_nxt.cmd_ready = 1'b1;
            m_nxt.tick = 16'h0;
            if (m_r.st == tw_pkg::M_BYTE) begin
                m_nxt.sda_oe = 1'b0;
            end
        end
    end

    // ***********************************
    // State register
    // ***********************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            m_r <= tw_pkg::MS_RST;
        end else if (clk_en) begin
            m_r <= m_nxt;
        end
    end

    assign link.scl = m_r.scl;
    assign link.m_sda_oe = m_r.sda_oe;
    assign cmd_ready = m_r.cmd_ready;
    assign rsp_valid = m_r.rsp_valid;
    assign rsp_data = m_r.rsp_data;
    assign rsp_ack = m_r.rsp_ack;
endmodule // tw_master_end
`default_nettype wire

/* File: hw/tw_pkg.sv */
/*
 * Shared constants, command codes, states and register images for both
 * ends of the two-wire link.
 * Assumes a 40 MHz system clock on both ends.
 */
package tw_pkg;
    // ***********************************
    // Timing
    // ***********************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SPIKE_NS = 50;
    localparam int FILT_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_WAIT_TIME_US = 100;
    localparam int PWR_WAIT_CYC =
        (POWER_UP_WAIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
        / (4 * CLK_PERIOD_NS);
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] RECOVER_CLOCKS = 4'h9;

    // ***********************************
    // Host commands, host states and slave states
    // ***********************************
    typedef enum logic [4:0] {
        CMD_START = 5'h01, CMD_STOP = 5'h02, CMD_WRITE = 5'h04,
        CMD_READ = 5'h08, CMD_RECOVER = 5'h10
    } cmd_t;
    typedef enum logic [5:0] {
        M_WAIT = 6'h01, M_IDLE = 6'h02, M_START = 6'h04,
        M_STOP = 6'h08, M_BYTE = 6'h10, M_RECOV = 6'h20
    } ms_state_t;
    typedef enum logic [5:0] {
        SL_STANDBY = 6'h01, SL_RX = 6'h02, SL_ACK = 6'h04,
        SL_TX = 6'h08, SL_MACK = 6'h10, SL_IGNORE = 6'h20
    } sl_state_t;

    // ***********************************
    // Register images
    // ***********************************
    typedef struct packed {
        sl_state_t st;
        logic [1:0] sy_a;
        logic [1:0] sy_b;
        logic [1:0] flt;
        logic [1:0][1:0] fcnt;
        logic [3:0] bit_cnt;
        logic [7:0] sh;
        logic first;
        logic rd;
        logic macked;
        logic sda_oe;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_is_addr;
        logic tx_take;
        logic start_p;
        logic stop_p;
        logic standby;
    } sl_reg_t;
    localparam sl_reg_t SL_RST = '{st: SL_STANDBY, sy_a: 2'h3, sy_b: 2'h3,
        flt: 2'h3, default: '0};

    typedef struct packed {
        ms_state_t st;
        logic [11:0] pwr_cnt;
        logic [15:0] tick;
        logic [1:0] ph;
        logic [3:0] bit_cnt;
        logic [8:0] sh;
        logic [8:0] rsh;
        logic sy_a;
        logic sy_b;
        logic scl;
        logic sda_oe;
        logic cmd_ready;
        logic rsp_valid;
        logic [7:0] rsp_data;
        logic rsp_ack;
    } ms_reg_t;
    localparam ms_reg_t MS_RST = '{st: M_WAIT, sy_a: 1'h1, sy_b: 1'h1,
        scl: 1'h1, default: '0};
endpackage

/* File: hw/tw_slave_end.sv */
/*
 * Bit-level front end of a two-wire serial memory slave.
 * Assumes byte decoding, address handling and the write cycle live in
 * the user logic, joined through the plain ports below.
 */
//
// Overview of operation
// - sample on SCL rise, drive after fall
// - bytes shift most significant bit first
// - nine clocks per byte, ninth is acknowledge
// - master clocks bytes without gaps
// - SDA changes only while SCL low
// - SDA fall with SCL high is Start
// - silent on SDA until Start seen
// - SDA rise with SCL high is Stop
// - repeated Start begins a new command
// - no limit on bytes per transfer
// - idle only when both lines high
// - receiver holds SDA low in ninth high
// - receiver releases SDA after ninth clock
// - master NACK makes device release SDA
// - Standby after reset, Stop, write done
// - ignore bus during reset, then Standby
// - master waits power-up time before commands
// - dummy clocks free SDA within nine
// - SDA only pulled low, never driven high
// - acknowledge address byte only on match
// - ignore bus during internal write cycle
`timescale 1ns/100ps
`default_nettype none
module tw_slave_end (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    tw_link_if.device link,
    input wire logic [6:0] sel_code,
    input wire logic wr_busy,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_is_addr,
    output logic rd_mode,
    output logic tx_take,
    output logic start_seen,
    output logic stop_seen,
    output logic standby
);
    tw_pkg::sl_reg_t s_r;
    tw_pkg::sl_reg_t s_nxt;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // ***********************************
    // Next state
    // ***********************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rx_valid = 1'b0;
        s_nxt.tx_take = 1'b0;
        s_nxt.start_p = 1'b0;
        s_nxt.stop_p = 1'b0;

        // Two stages, then a stability count; only the second stage
        // feeds the filter
        s_nxt.sy_a = {link.sda, link.scl};
        s_nxt.sy_b = s_r.sy_a;
        for (int i = 0; i < 2; i++) begin
            if (s_r.sy_b[i] != s_r.flt[i]) begin
                if (s_r.fcnt[i] == 2'(tw_pkg::FILT_CYC - 1)) begin
                    s_nxt.flt[i] = s_r.sy_b[i];
                    s_nxt.fcnt[i] = 2'h0;
                end else begin
                    s_nxt.fcnt[i] = s_r.fcnt[i] + 2'h1;
                end
            end else begin
                s_nxt.fcnt[i] = 2'h0;
            end
        end

        scl_rise = ~s_r.flt[0] & s_nxt.flt[0];
        scl_fall = s_r.flt[0] & ~s_nxt.flt[0];
        // Line change while SCL stays high marks Start or Stop
        start_det = s_r.flt[0] & s_nxt.flt[0] & s_r.flt[1]
            & ~s_nxt.flt[1];
        stop_det = s_r.flt[0] & s_nxt.flt[0] & ~s_r.flt[1]
            & s_nxt.flt[1];

        if (wr_busy) begin
            // Deaf and silent during the nonvolatile cycle
            s_nxt.st = tw_pkg::SL_STANDBY;
            s_nxt.sda_oe = 1'b0;
        end else if (start_det) begin
            s_nxt.st = tw_pkg::SL_RX;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.first = 1'b1;
            s_nxt.sda_oe = 1'b0;
            s_nxt.start_p = 1'b1;
        end else if (stop_det) begin
            s_nxt.st = tw_pkg::SL_STANDBY;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
            s_nxt.stop_p = 1'b1;
        end else begin
            case (s_r.st)
                tw_pkg::SL_RX: begin
                    if (scl_rise) begin
                        s_nxt.sh = {s_r.sh[6:0], s_r.flt[1]};
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end else if (scl_fall
                            && s_r.bit_cnt == tw_pkg::BITS_PER_BYTE) begin
                        // Byte count is unbounded; only framing stops it
                        s_nxt.rx_data = s_r.sh;
                        s_nxt.rx_valid = 1'b1;
                        s_nxt.rx_is_addr = s_r.first;
                        s_nxt.first = 1'b0;
                        if (!s_r.first || s_r.sh[7:1] == sel_code) begin
                            s_nxt.st = tw_pkg::SL_ACK;
                            s_nxt.sda_oe = 1'b1;
                            if (s_r.first) begin
                                s_nxt.rd = s_r.sh[0];
                            end
                        end else begin
                            s_nxt.st = tw_pkg::SL_IGNORE;
                        end
                    end
                end
                tw_pkg::SL_ACK: begin
                    if (scl_fall) begin
                        s_nxt.bit_cnt = 4'h0;
                        if (s_r.rd) begin
                            s_nxt.st = tw_pkg::SL_TX;
                            s_nxt.sh = tx_data;
                            s_nxt.sda_oe = ~tx_data[7];
                            s_nxt.tx_take = 1'b1;
                        end else begin
                            s_nxt.st = tw_pkg::SL_RX;
                            s_nxt.sda_oe = 1'b0;
                        end
                    end
                end
                tw_pkg::SL_TX: begin
                    if (scl_rise) begin
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (s_r.bit_cnt == tw_pkg::BITS_PER_BYTE) begin
                            // Free the line for the master's answer
                            s_nxt.st = tw_pkg::SL_MACK;
                            s_nxt.sda_oe = 1'b0;
                        end else begin
                            s_nxt.sh = {s_r.sh[6:0], 1'b0};
                            s_nxt.sda_oe = ~s_r.sh[6];
                        end
                    end
                end
                tw_pkg::SL_MACK: begin
                    if (scl_rise) begin
                        s_nxt.macked = ~s_r.flt[1];
                    end else if (scl_fall) begin
                        if (s_r.macked) begin
                            s_nxt.st = tw_pkg::SL_TX;
                            s_nxt.bit_cnt = 4'h0;
                            s_nxt.sh = tx_data;
                            s_nxt.sda_oe = ~tx_data[7];
                            s_nxt.tx_take = 1'b1;
                        end else begin
                            // Stay released until Stop or Start
                            s_nxt.st = tw_pkg::SL_IGNORE;
                        end
                    end
                end
                default: begin
                    // Standby and not addressed: watch, never drive
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        s_nxt.standby = (s_nxt.st == tw_pkg::SL_STANDBY) & ~wr_busy;
    end

    // ***********************************
    // State register
    // ***********************************
    // Reset holds the front end deaf; release lands in Standby
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= tw_pkg::SL_RST;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign link.s_sda_oe = s_r.sda_oe;
    assign rx_data = s_r.rx_data;
    assign rx_valid = s_r.rx_valid;
    assign rx_is_addr = s_r.rx_is_addr;
    assign rd_mode = s_r.rd;
    assign tx_take = s_r.tx_take;
    assign start_seen = s_r.start_p;
    assign stop_seen = s_r.stop_p;
    assign standby = s_r.standby;
endmodule // tw_slave_end
`default_nettype wire
